// ===== inc/ovsup_pkg.sv
// package for the output voltage supervisor: register map, defaults, timing
// assumes one 20 MHz clock and a digitizer delivering sense samples in 1/256 V units
package ovsup_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned OV_DLY_NS = 200;
  localparam int unsigned OV_DLY_CYC = (OV_DLY_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned PG_STEP_MS = 1;
  localparam int unsigned PG_STEP_CYC = PG_STEP_MS * (CLK_HZ / 1000);
  localparam logic [3:0] PG_DLY_MAX = 4'ha;
  // voltages in 1/256 V units, 16 bit
  localparam logic [15:0] PG_ON_DEF = 16'h0073;
  localparam logic [15:0] PG_OFF_DEF = 16'h006b;
  localparam logic [15:0] OV_DEF = 16'h009a;
  localparam logic [15:0] PG_TRACK_OFS = 16'h00a1;
  localparam logic [15:0] OV_TRACK_OFS = 16'h00a8;
  localparam logic [15:0] VREF_DEF = 16'h0080;
  localparam logic [15:0] SCALE_DEF = 16'h0001;
  localparam logic [15:0] FREQ_DEF = 16'h025f;
  localparam logic [15:0] UV_FLT_DEF = 16'h0000;
  localparam logic [15:0] UV_WRN_DEF = 16'h0000;
  localparam logic [15:0] OV_WRN_DEF = 16'hffff;
  localparam logic [15:0] VIN_ON_DEF = 16'h0900;
  localparam logic [15:0] VIN_OFF_DEF = 16'h0800;
  // register offsets
  localparam logic [7:0] A_READ_VOUT = 8'h00;
  localparam logic [7:0] A_OV_WARN = 8'h04;
  localparam logic [7:0] A_UV_FAULT = 8'h08;
  localparam logic [7:0] A_UV_WARN = 8'h0c;
  localparam logic [7:0] A_PG_ON = 8'h10;
  localparam logic [7:0] A_PG_OFF = 8'h14;
  localparam logic [7:0] A_PG_DLY = 8'h18;
  localparam logic [7:0] A_OV_FAULT = 8'h1c;
  localparam logic [7:0] A_OV_RESP = 8'h20;
  localparam logic [7:0] A_VREF = 8'h24;
  localparam logic [7:0] A_SCALE = 8'h28;
  localparam logic [7:0] A_FREQ = 8'h2c;
  localparam logic [7:0] A_VIN_ON = 8'h30;
  localparam logic [7:0] A_VIN_OFF = 8'h34;
  localparam logic [7:0] A_OPERATION = 8'h38;
  localparam logic [7:0] A_STATUS = 8'h3c;
  localparam logic [7:0] A_CLEAR = 8'h40;
  localparam logic [7:0] A_IRQ_EN = 8'h44;
  // status bit positions
  localparam int unsigned ST_OV_FLT = 0;
  localparam int unsigned ST_OV_WRN = 1;
  localparam int unsigned ST_UV_FLT = 2;
  localparam int unsigned ST_UV_WRN = 3;
  localparam int unsigned ST_W = 4;
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } ovsup_bus_t;
  typedef struct packed {
    logic high_side_drive;
    logic low_side_drive;
    logic continuous_cond;
  } ovsup_drv_t;
endpackage : ovsup_pkg

// ===== core/ovsup_top.sv
// output voltage supervisor: telemetry, power good, overvoltage response, faults
// assumes sense samples and the tracking input are digitized on i_clk_sys;
// pins (enable, tracking select, pwm request) are asynchronous
`timescale 1ns/1ns
`default_nettype none
module ovsup_top (
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire ovsup_pkg::ovsup_bus_t i_bus,
  output logic [15:0] o_rdata,
  input wire logic [15:0] i_sense,
  input wire logic i_sense_vld,
  input wire logic [15:0] i_tracking_reference_input,
  input wire logic [15:0] i_power_input_voltage,
  input wire logic i_enable,
  input wire logic i_track_mode,
  input wire logic i_digital_mode,
  input wire logic i_pwm_high,
  output ovsup_pkg::ovsup_drv_t o_drv,
  output logic o_power_good_output,
  output logic o_ov_trip,
  output logic o_vin_ok,
  output logic o_alert_line,
  output logic o_irq
);
  import ovsup_pkg::*;

  // two stages per pin; only the second is read, the first may still be settling
  logic [1:0] en_s_q, trk_s_q, pwm_s_q;
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      en_s_q <= 2'h0;
      trk_s_q <= 2'h0;
      pwm_s_q <= 2'h0;
    end else begin
      en_s_q <= {en_s_q[0], i_enable};
      trk_s_q <= {trk_s_q[0], i_track_mode};
      pwm_s_q <= {pwm_s_q[0], i_pwm_high};
    end
  end
  wire logic en_s = en_s_q[1];
  wire logic trk_s = trk_s_q[1];
  wire logic pwm_s = pwm_s_q[1];
  logic en_d1_q;
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) en_d1_q <= 1'b0;
    else en_d1_q <= en_s;
  end
  wire logic en_rise = en_s & ~en_d1_q;

  // registers
  logic [15:0] vout_q, ov_wrn_q, uv_flt_q, uv_wrn_q, pg_on_q, pg_off_q, ov_flt_q;
  logic [15:0] vref_q, scale_q, vin_on_q, vin_off_q;
  logic [3:0] pg_dly_q;
  logic ov_ignore_q;
  logic [ST_W-1:0] status_q, irq_en_q;
  wire logic wr = i_bus.wr;
  wire logic [7:0] wa = i_bus.addr;
  wire logic [15:0] wd = i_bus.wdata;
  wire logic op_restart = wr && wa == A_OPERATION && wd[7] && i_digital_mode;

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      ov_wrn_q <= OV_WRN_DEF;
      uv_flt_q <= UV_FLT_DEF;
      uv_wrn_q <= UV_WRN_DEF;
      pg_on_q <= PG_ON_DEF;
      pg_off_q <= PG_OFF_DEF;
      ov_flt_q <= OV_DEF;
      pg_dly_q <= 4'h0;
      ov_ignore_q <= 1'b0;
      vref_q <= VREF_DEF;
      scale_q <= SCALE_DEF;
      vin_on_q <= VIN_ON_DEF;
      vin_off_q <= VIN_OFF_DEF;
      irq_en_q <= '0;
    end else if (wr) begin
      if (wa == A_OV_WARN) ov_wrn_q <= wd;
      else if (wa == A_UV_FAULT) uv_flt_q <= wd;
      else if (wa == A_UV_WARN) uv_wrn_q <= wd;
      else if (wa == A_PG_ON) pg_on_q <= wd;
      else if (wa == A_PG_OFF) pg_off_q <= wd;
      else if (wa == A_PG_DLY) pg_dly_q <= (wd[3:0] > PG_DLY_MAX) ? PG_DLY_MAX : wd[3:0];
      else if (wa == A_OV_FAULT) ov_flt_q <= wd;
      else if (wa == A_OV_RESP) ov_ignore_q <= wd[0];
      else if (wa == A_VREF) vref_q <= wd;
      else if (wa == A_SCALE) scale_q <= wd;
      else if (wa == A_VIN_ON) vin_on_q <= wd;
      else if (wa == A_VIN_OFF) vin_off_q <= wd;
      else if (wa == A_IRQ_EN) irq_en_q <= wd[ST_W-1:0];
    end
  end

  // telemetry sample
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) vout_q <= 16'h0000;
    else if (i_sense_vld) vout_q <= i_sense;
  end

  // read path, data one cycle after the strobe
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) o_rdata <= 16'h0000;
    else if (i_bus.rd) begin
      if (wa == A_READ_VOUT) o_rdata <= vout_q;
      else if (wa == A_OV_WARN) o_rdata <= ov_wrn_q;
      else if (wa == A_UV_FAULT) o_rdata <= uv_flt_q;
      else if (wa == A_UV_WARN) o_rdata <= uv_wrn_q;
      else if (wa == A_PG_ON) o_rdata <= pg_on_q;
      else if (wa == A_PG_OFF) o_rdata <= pg_off_q;
      else if (wa == A_PG_DLY) o_rdata <= {12'h000, pg_dly_q};
      else if (wa == A_OV_FAULT) o_rdata <= ov_flt_q;
      else if (wa == A_OV_RESP) o_rdata <= {15'h0000, ov_ignore_q};
      else if (wa == A_VREF) o_rdata <= vref_q;
      else if (wa == A_SCALE) o_rdata <= scale_q;
      else if (wa == A_FREQ) o_rdata <= FREQ_DEF;
      else if (wa == A_VIN_ON) o_rdata <= vin_on_q;
      else if (wa == A_VIN_OFF) o_rdata <= vin_off_q;
      else if (wa == A_STATUS) o_rdata <= {12'h000, status_q};
      else if (wa == A_IRQ_EN) o_rdata <= {12'h000, irq_en_q};
      else o_rdata <= 16'h0000;
    end else o_rdata <= 16'h0000;
  end

  // thresholds; saturating sum keeps a large vout from wrapping
  function automatic logic [15:0] clamp_track(input logic [15:0] thr, input logic [15:0] vo,
                                              input logic [15:0] ofs);
    logic [16:0] lim;
    logic [15:0] hi;
    lim = {1'b0, vo} + {1'b0, ofs};
    hi = lim[16] ? 16'hffff : lim[15:0];
    clamp_track = (thr > hi) ? hi : thr;
  endfunction : clamp_track

  logic [15:0] pg_hi, pg_lo, ov_thr, ov_rel;
  logic [17:0] trk_x;
  always_comb begin
    // about 1.2 times: 1 + 1/4 - 1/16 + 1/64
    trk_x = {2'b00, i_tracking_reference_input} + {4'h0, i_tracking_reference_input[15:2]}
            - {6'h00, i_tracking_reference_input[15:4]}
            + {8'h00, i_tracking_reference_input[15:6]};
    if (i_digital_mode) begin
      pg_hi = clamp_track(pg_on_q, vout_q, PG_TRACK_OFS);
      pg_lo = clamp_track(pg_off_q, vout_q, PG_TRACK_OFS);
    end else begin
      pg_hi = PG_ON_DEF;
      pg_lo = PG_OFF_DEF;
    end
    if (trk_s) ov_thr = trk_x[17:16] != 2'b00 ? 16'hffff : trk_x[15:0];
    else if (i_digital_mode) ov_thr = clamp_track(ov_flt_q, vout_q, OV_TRACK_OFS);
    else ov_thr = OV_DEF;
    // 1 - 1/16 + 1/64 - 1/256 sits just under 95 percent, so the low side never lets go early
    ov_rel = ov_thr - {4'h0, ov_thr[15:4]} + {6'h00, ov_thr[15:6]} - {8'h00, ov_thr[15:8]};
  end

  // overvoltage trip after the filter delay
  logic [$clog2(OV_DLY_CYC+1)-1:0] ov_cnt_q;
  wire logic ov_raw = i_sense > ov_thr;
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      ov_cnt_q <= '0;
      o_ov_trip <= 1'b0;
    end else if (!ov_raw) begin
      ov_cnt_q <= '0;
      o_ov_trip <= 1'b0;
    end else if (ov_cnt_q < OV_DLY_CYC[$bits(ov_cnt_q)-1:0] - 1'b1) begin
      ov_cnt_q <= ov_cnt_q + 1'b1;
    end else o_ov_trip <= 1'b1;
  end

  // high side latch and low side hold
  logic hs_off_q, ls_hold_q;
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      hs_off_q <= 1'b0;
      ls_hold_q <= 1'b0;
    end else begin
      if (o_ov_trip && !ov_ignore_q) hs_off_q <= 1'b1;
      else if (en_rise || op_restart) hs_off_q <= 1'b0;
      if (o_ov_trip && !ov_ignore_q) ls_hold_q <= 1'b1;
      else if (i_sense < ov_rel) ls_hold_q <= 1'b0;
    end
  end
  wire logic hs_block = hs_off_q | (o_ov_trip & ~ov_ignore_q);
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) o_drv <= '0;
    else begin
      o_drv.high_side_drive <= pwm_s & ~hs_block & ~ls_hold_q;
      o_drv.low_side_drive <= ls_hold_q | (~pwm_s & ~hs_block);
      o_drv.continuous_cond <= trk_s;
    end
  end

  // power good with programmable delay
  logic in_win_q;
  logic [3:0] pg_ms_q;
  localparam int unsigned PG_CYC_W = $clog2(PG_STEP_CYC);
  logic [PG_CYC_W-1:0] pg_cyc_q;
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) in_win_q <= 1'b0;
    else if (i_sense >= pg_hi) in_win_q <= 1'b1;
    else if (i_sense < pg_lo) in_win_q <= 1'b0;
  end
  wire logic pg_cond = in_win_q && !hs_block && !ov_raw;
  wire logic [3:0] dly_eff = i_digital_mode ? pg_dly_q : 4'h0;
  always_ff @(posedge i_clk_sys) begin
    if (i_srst || !pg_cond) begin
      pg_ms_q <= 4'h0;
      pg_cyc_q <= '0;
    end else if (pg_ms_q < dly_eff) begin
      if (pg_cyc_q == PG_CYC_W'(PG_STEP_CYC - 1)) begin
        pg_cyc_q <= '0;
        pg_ms_q <= pg_ms_q + 1'b1;
      end else pg_cyc_q <= pg_cyc_q + 1'b1;
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) o_power_good_output <= 1'b0;
    else o_power_good_output <= pg_cond && pg_ms_q >= dly_eff;
  end

  // input undervoltage lockout with hysteresis
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) o_vin_ok <= 1'b0;
    else if (i_power_input_voltage >= vin_on_q) o_vin_ok <= 1'b1;
    else if (i_power_input_voltage < vin_off_q) o_vin_ok <= 1'b0;
  end

  // sticky status; a set in the clear cycle wins
  logic [ST_W-1:0] ev;
  always_comb begin
    ev = '0;
    ev[ST_OV_FLT] = o_ov_trip;
    ev[ST_OV_WRN] = i_sense_vld && i_sense > ov_wrn_q;
    ev[ST_UV_FLT] = i_sense_vld && i_sense < uv_flt_q;
    ev[ST_UV_WRN] = i_sense_vld && i_sense < uv_wrn_q;
  end
  wire logic [ST_W-1:0] clr = (wr && wa == A_CLEAR) ? wd[ST_W-1:0] : '0;
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) status_q <= '0;
    else status_q <= (status_q & ~clr) | ev;
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) o_alert_line <= 1'b0;
    else o_alert_line <= |status_q;
  end
  assign o_irq = |(status_q & irq_en_q);

  sequence s_trip_held;
    o_ov_trip && !ov_ignore_q;
  endsequence
  // overvoltage that stays long enough to pass the four-cycle filter
  sequence s_ov_held;
    $rose(ov_raw) ##1 ov_raw [*3];
  endsequence
  AST_OV_DELAY: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    s_ov_held |-> !o_ov_trip ##1 o_ov_trip) else $error("ov trip too early or late");
  AST_HS_LATCH: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    s_trip_held |=> hs_off_q && !o_drv.high_side_drive) else $error("high side not latched off");
  AST_PG_LOW_ON_TRIP: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    s_trip_held |=> !o_power_good_output) else $error("power good high during trip");
  AST_LS_HOLD: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    ls_hold_q && $past(i_sense) >= $past(ov_rel) && !$past(ov_raw) |-> o_drv.low_side_drive ##0 ls_hold_q)
    else $error("low side released early");
  AST_LATCH_KEEP: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    hs_off_q && !en_rise && !op_restart |=> hs_off_q) else $error("latch cleared without restart");
  AST_IGNORE: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    o_ov_trip && ov_ignore_q && !hs_off_q |=> status_q[ST_OV_FLT] && !hs_off_q) else $error("ignore mode wrong");
  AST_STICKY: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    status_q[ST_UV_FLT] && !clr[ST_UV_FLT] |=> status_q[ST_UV_FLT]) else $error("status bit lost");
  AST_UV_SET: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    i_sense_vld && i_sense < uv_wrn_q |=> status_q[ST_UV_WRN] ##1 o_alert_line) else $error("uv warn not flagged");
  AST_FREQ: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    i_bus.rd && wa == A_FREQ |=> o_rdata == FREQ_DEF) else $error("frequency readback wrong");
  AST_PG_WIN: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    o_power_good_output |-> $past(in_win_q)) else $error("power good outside window");
  AST_PG_IMMED: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    !i_digital_mode && pg_cond |=> o_power_good_output) else $error("power good delayed in analog mode");
  AST_DLY_CLAMP: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    pg_dly_q <= PG_DLY_MAX) else $error("power good delay above limit");
  AST_CCM: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    trk_s |=> o_drv.continuous_cond) else $error("tracking without continuous conduction");
  AST_VIN_ON: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    i_power_input_voltage >= vin_on_q |=> o_vin_ok) else $error("input supply not reported good");
  AST_VIN_OFF: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    i_power_input_voltage < vin_off_q && i_power_input_voltage < vin_on_q |=> !o_vin_ok)
    else $error("input supply not reported low");
endmodule : ovsup_top
`default_nettype wire

// ===== verification/ovsup_host_model.sv
// host-side register master for the supervisor: one-cycle write and read strobes
// assumes the shared system clock and a slave that never stalls
`timescale 1ns/1ns
`default_nettype none
module ovsup_host_model (
  input wire logic i_clk,
  output var ovsup_pkg::ovsup_bus_t o_bus,
  input wire logic [15:0] i_rdata
);
  import ovsup_pkg::*;
  initial begin
    o_bus = '0;
  end
  // the strobe is dropped on the next edge, so back-to-back calls still see one idle edge
  task automatic bus_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clk);
    o_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_clk);
    o_bus <= '0;
  endtask : bus_wr
  // read data only stand in the cycle after the strobe, so sample it mid-cycle there
  task automatic bus_rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge i_clk);
    o_bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge i_clk);
    o_bus <= '0;
    @(negedge i_clk);
    d = i_rdata;
  endtask : bus_rd
endmodule : ovsup_host_model
`default_nettype wire

// ===== verification/ovsup_top_test.sv
// self-checking bench for the supervisor: defaults, telemetry, power good, overvoltage, status
// assumes a 20 MHz system clock and the host model on the register port
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin error_cnt++; \
  $display("mismatch %s exp %0h got %0h", nm, exp, got); end end
module ovsup_top_test;
  import ovsup_pkg::*;
  logic clk, srst, vld, enable, track, digital, pwm;
  logic [15:0] sense, trk, vin, rdata, d;
  ovsup_bus_t bus;
  ovsup_drv_t drv;
  logic pg, trip, vin_ok, alert, irq;
  int error_cnt = 0;
  int num_checks = 0;
  logic [15:0] ovw, uvf, uvw, s;
  logic [3:0] en, e;
  logic [7:0] addrs [7] = '{A_FREQ, A_VREF, A_SCALE, A_PG_ON, A_PG_OFF, A_OV_FAULT, 8'h48};
  logic [15:0] defs [7] = '{FREQ_DEF, VREF_DEF, SCALE_DEF, PG_ON_DEF, PG_OFF_DEF, OV_DEF, 16'h0000};
  ovsup_host_model u_host (.i_clk(clk), .o_bus(bus), .i_rdata(rdata));
  ovsup_top u_dut (.i_clk_sys(clk), .i_srst(srst), .i_bus(bus), .o_rdata(rdata), .i_sense(sense),
    .i_sense_vld(vld), .i_tracking_reference_input(trk), .i_power_input_voltage(vin),
    .i_enable(enable), .i_track_mode(track), .i_digital_mode(digital), .i_pwm_high(pwm),
    .o_drv(drv), .o_power_good_output(pg), .o_ov_trip(trip), .o_vin_ok(vin_ok),
    .o_alert_line(alert), .o_irq(irq));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  function automatic logic [3:0] exp_st(input logic [15:0] v, input logic [15:0] w, input logic [15:0] f,
                                        input logic [15:0] u);
    return {v < u, v < f, v > w, 1'b0};
  endfunction : exp_st
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : wait_n
  task automatic set_sense(input logic [15:0] v, input int n);
    @(posedge clk);
    sense <= v;
    wait_n(n);
  endtask : set_sense
  task automatic sample(input logic [15:0] v);
    @(posedge clk);
    sense <= v;
    vld <= 1'b1;
    @(posedge clk);
    vld <= 1'b0;
    wait_n(2);
  endtask : sample
  task automatic set_vin(input logic [15:0] v);
    @(posedge clk);
    vin <= v;
    wait_n(2);
  endtask : set_vin
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] x);
    u_host.bus_rd(a, d);
    `CHK("rdata", x, d)
  endtask : rd_chk
  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim
  // about 21000 cycles are planned, almost all of them the 1 ms power good delay
  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    end_sim();
  end
  initial begin
    srst = 1'b1; vld = 1'b0; enable = 1'b1; track = 1'b0; digital = 1'b0; pwm = 1'b1;
    sense = 16'h0080; trk = 16'h0080; vin = 16'h0a00;
    void'($urandom(93656));
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    wait_n(3);
    u_host.bus_wr(A_FREQ, 16'h1234);
    for (int i = 0; i < 7; i++) begin
      rd_chk(addrs[i], defs[i]);
    end
    sample(16'h0080);
    rd_chk(A_READ_VOUT, 16'h0080);
    `CHK("pg", 1'b1, pg)
    set_sense(16'h0060, 3);
    `CHK("pg", 1'b0, pg)
    set_sense(16'h0080, 3);
    // analog mode, default response
    set_sense(16'h009b, 2);
    `CHK("trip", 1'b0, trip)
    wait_n(6);
    `CHK("trip", 1'b1, trip)
    `CHK("hs", 1'b0, drv.high_side_drive)
    `CHK("pg", 1'b0, pg)
    `CHK("ls", 1'b1, drv.low_side_drive)
    set_sense(16'h0094, 3);
    `CHK("ls", 1'b1, drv.low_side_drive)
    set_sense(16'h0080, 3);
    `CHK("ls", 1'b0, drv.low_side_drive)
    `CHK("hs", 1'b0, drv.high_side_drive)
    @(posedge clk);
    enable <= 1'b0;
    wait_n(4);
    @(posedge clk);
    enable <= 1'b1;
    wait_n(5);
    `CHK("hs", 1'b1, drv.high_side_drive)
    // digital mode, ignore response still flags
    @(posedge clk);
    digital <= 1'b1;
    u_host.bus_wr(A_CLEAR, 16'h000f);
    u_host.bus_wr(A_OV_RESP, 16'h0001);
    u_host.bus_wr(A_IRQ_EN, 16'h0001);
    set_sense(16'h00a0, 8);
    `CHK("trip", 1'b1, trip)
    `CHK("hs", 1'b1, drv.high_side_drive)
    `CHK("alert", 1'b1, alert)
    `CHK("irq", 1'b1, irq)
    set_sense(16'h0080, 3);
    rd_chk(A_STATUS, 16'h0001);
    u_host.bus_wr(A_IRQ_EN, 16'h0000);
    wait_n(1);
    `CHK("irq", 1'b0, irq)
    `CHK("alert", 1'b1, alert)
    u_host.bus_wr(A_CLEAR, 16'h0001);
    wait_n(2);
    `CHK("alert", 1'b0, alert)
    u_host.bus_wr(A_OV_RESP, 16'h0000);
    set_sense(16'h00a0, 8);
    `CHK("hs", 1'b0, drv.high_side_drive)
    set_sense(16'h0080, 3);
    u_host.bus_wr(A_OPERATION, 16'h0080);
    wait_n(3);
    `CHK("hs", 1'b1, drv.high_side_drive)
    // random limits and samples, limits rewritten before every sample
    for (int i = 0; i < 16; i++) begin
      ovw = 16'h0010 + 16'($urandom_range(0, 128));
      uvf = 16'h0010 + 16'($urandom_range(0, 128));
      uvw = 16'h0010 + 16'($urandom_range(0, 128));
      s = 16'h0010 + 16'($urandom_range(0, 128));
      en = 4'($urandom_range(0, 15));
      while (s == ovw || s == uvf || s == uvw) begin
        s = 16'h0010 + 16'($urandom_range(0, 128));
      end
      e = exp_st(s, ovw, uvf, uvw);
      u_host.bus_wr(A_OV_WARN, ovw);
      u_host.bus_wr(A_UV_FAULT, uvf);
      u_host.bus_wr(A_UV_WARN, uvw);
      u_host.bus_wr(A_IRQ_EN, {12'h000, en});
      u_host.bus_wr(A_CLEAR, 16'h000f);
      sample(s);
      rd_chk(A_STATUS, {12'h000, e});
      `CHK("irq", |(e & en), irq)
    end
    // digital window from registers, then the programmed delay
    sample(16'h0080);
    u_host.bus_wr(A_PG_ON, 16'h0088);
    u_host.bus_wr(A_PG_OFF, 16'h0084);
    set_sense(16'h0086, 3);
    `CHK("pg", 1'b0, pg)
    u_host.bus_wr(A_PG_DLY, 16'h000f);
    rd_chk(A_PG_DLY, 16'h000a);
    u_host.bus_wr(A_PG_DLY, 16'h0001);
    set_sense(16'h0088, 3);
    `CHK("pg", 1'b0, pg)
    wait_n(19990);
    `CHK("pg", 1'b0, pg)
    wait_n(20);
    `CHK("pg", 1'b1, pg)
    // far-off limits fall back to tracking the reported output
    u_host.bus_wr(A_PG_DLY, 16'h0000);
    set_sense(16'h0080, 3);
    u_host.bus_wr(A_PG_ON, 16'h0300);
    u_host.bus_wr(A_OV_FAULT, 16'hffff);
    set_sense(16'h0125, 3);
    `CHK("pg", 1'b1, pg)
    `CHK("trip", 1'b0, trip)
    set_sense(16'h012a, 8);
    `CHK("trip", 1'b1, trip)
    // tracking: threshold near 1.2 times the reference, continuous conduction
    set_sense(16'h0080, 3);
    @(posedge clk);
    track <= 1'b1;
    wait_n(4);
    `CHK("ccm", 1'b1, drv.continuous_cond)
    set_sense(16'h0090, 8);
    `CHK("trip", 1'b0, trip)
    set_sense(16'h00a0, 8);
    `CHK("trip", 1'b1, trip)
    // input lockout hysteresis and a programmed turn-on level
    `CHK("vin", 1'b1, vin_ok)
    set_vin(16'h0850);
    `CHK("vin", 1'b1, vin_ok)
    set_vin(16'h07f0);
    `CHK("vin", 1'b0, vin_ok)
    u_host.bus_wr(A_VIN_ON, 16'h0b00);
    set_vin(16'h0a00);
    `CHK("vin", 1'b0, vin_ok)
    set_vin(16'h0b00);
    `CHK("vin", 1'b1, vin_ok)
    end_sim();
  end
endmodule : ovsup_top_test
`undef CHK
`default_nettype wire
